/* design/irq_ctrl_pkg.sv */
`default_nettype none
package irq_ctrl_pkg;
	// ***********************************
	// register addresses
	// ***********************************
	localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
	localparam logic [7:0] ADDR_ENABLE_MAIN = 8'ha8;
	localparam logic [7:0] ADDR_PRIO_MAIN = 8'hb8;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'hd8;
	localparam logic [7:0] ADDR_EXT_ENABLES = 8'he8;
	localparam logic [7:0] ADDR_EXT_PRIO = 8'hf8;

	// ***********************************
	// fields and fixed read values
	// ***********************************
	localparam int GATE_BIT = 7;
	localparam int BAUD_BIT = 7;
	localparam int PDF_BIT = 3;
	localparam int EXT_FLAG_LSB = 4;
	localparam int EXT_W = 5;
	localparam int EXT_FLAG_W = 4;
	localparam int MAIN_W = 7;
	localparam logic [7:0] EXT_RSVD_ONES = 8'he0;
	localparam logic [7:0] FLAGS_RSVD_ONES = 8'h08;
	localparam logic [7:0] CTRL_RSVD_ONES = 8'h40;
	localparam logic [7:0] PRIO_RSVD_ONES = 8'h80;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// ***********************************
	// interrupt numbers, lowest polls first
	// ***********************************
	localparam int NUM_SRC = 13;
	localparam int NUM_W = 4;
	localparam int SRC_IO0 = 0;
	localparam int SRC_T0 = 1;
	localparam int SRC_IO1 = 2;
	localparam int SRC_T1 = 3;
	localparam int SRC_T2 = 5;
	localparam int SRC_UART1 = 6;
	localparam int SRC_EXT8 = 8;
	localparam int SRC_PD = 12;

	typedef struct packed {
		logic timer0_overflow_flag;
		logic timer1_overflow_flag;
		logic timer2_overflow_flag;
		logic timer2_external_flag;
		logic uart1_tx_done_flag;
		logic uart1_rx_done_flag;
		logic [EXT_FLAG_W-1:0] ext_event;
		logic power_down_event;
	} periph_events_t;

	typedef struct packed {
		logic ack;
		logic reti;
	} core_ctrl_t;
endpackage
`default_nettype wire

/* design/pin_sync2.sv */
`default_nettype none
module pin_sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic pin_i,
	output logic sync_o
);
	logic stage1;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			stage1 <= RESET_VAL;
			sync_o <= RESET_VAL;
		end
		else
		begin
			stage1 <= pin_i;
			sync_o <= stage1;
		end
	end
endmodule
`default_nettype wire

/* design/first_set_picker.sv */
`default_nettype none
module first_set_picker #(
	parameter int N = 13,
	parameter int W = 4
) (
	input wire logic [N-1:0] req_i,
	output logic found_o,
	output logic [W-1:0] idx_o
);
	// scan downward so the lowest set index wins
	always_comb
	begin
		found_o = 1'b0;
		idx_o = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req_i[i])
			begin
				found_o = 1'b1;
				idx_o = W'(i);
			end
		end
	end
endmodule
`default_nettype wire

/* design/cpu_irq_ctrl.sv */
`default_nettype none
// Functional notes
// - global gate off blocks all interrupts
// - uart1 enable gates tx and rx flags
// - timer2 enable gates overflow and external flags
// - timer1 enable gates timer1 overflow
// - timer0 enable gates timer0 overflow
// - io enables gate falling edge or low
// - extended enables for interrupts 8 to 12
// - flags of interrupts 11..8 in bits 7..4
// - software set flag raises enabled request
// - power-down flag repeats request until cleared
// - software set power-down flag raises request
// - baud doubler bit doubles uart1 rate
// - reserved bits read fixed values, except reserved enable bit 4 and main priority bit 4, which read back as written
// - main priority bits select level per source
// - extended priority bits select level 8..12
// - level one preempts level zero only
// - same level requests follow polling order
module cpu_irq_ctrl (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire irq_ctrl_pkg::periph_events_t events_i,
	input wire logic io_irq0_pin_i,
	input wire logic io_irq1_pin_i,
	input wire logic [1:0] io_edge_mode_i,
	input wire irq_ctrl_pkg::core_ctrl_t core_i,
	output logic irq_req_o,
	output logic [irq_ctrl_pkg::NUM_W-1:0] irq_num_o,
	output logic irq_level_o,
	output logic uart1_baud_doubler_o
);
	localparam int N = irq_ctrl_pkg::NUM_SRC;
	localparam int NW = irq_ctrl_pkg::NUM_W;

	// ***********************************
	// registers
	// ***********************************
	logic [7:0] interrupt_enable_main;
	logic [irq_ctrl_pkg::MAIN_W-1:0] priority_select_main;
	logic [irq_ctrl_pkg::EXT_W-1:0] extended_irq_enables;
	logic [irq_ctrl_pkg::EXT_W-1:0] extended_priority_select;
	logic [irq_ctrl_pkg::EXT_FLAG_W-1:0] ext_flags;
	logic power_down_flag;
	logic [1:0] io_edge_flag;
	logic [1:0] io_prev;
	logic hi_busy;
	logic lo_busy;
	logic [N-1:0] active_q;
	logic [N-1:0] prio_q;

	// ***********************************
	// pin synchronisers
	// ***********************************
	logic io0_sync;
	logic io1_sync;

	pin_sync2 #(.RESET_VAL(1'b1)) u_sync_io0 (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pin_i(io_irq0_pin_i),
		.sync_o(io0_sync)
	);

	pin_sync2 #(.RESET_VAL(1'b1)) u_sync_io1 (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pin_i(io_irq1_pin_i),
		.sync_o(io1_sync)
	);

	// ***********************************
	// address decode
	// ***********************************
	wire logic wr_flags = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_FLAGS;
	wire logic wr_en_main = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_MAIN;
	wire logic wr_prio_main = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_MAIN;
	wire logic wr_ctrl = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_CTRL;
	wire logic wr_ext_en = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_ENABLES;
	wire logic wr_ext_prio = sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_PRIO;
	wire logic global_irq_gate = interrupt_enable_main[irq_ctrl_pkg::GATE_BIT];

	// ***********************************
	// source, enable and level vectors
	// ***********************************
	wire logic [1:0] io_pin_low = {~io1_sync, ~io0_sync};
	wire logic [1:0] io_fall = io_prev & io_pin_low;
	wire logic [1:0] io_req = (io_edge_mode_i & io_edge_flag) | (~io_edge_mode_i & io_pin_low);
	logic [N-1:0] src_flags;
	logic [N-1:0] src_enables;
	logic [N-1:0] src_prio;
	logic [N-1:0] active;

	always_comb
	begin
		src_flags = '0;
		src_flags[irq_ctrl_pkg::SRC_IO0] = io_req[0];
		src_flags[irq_ctrl_pkg::SRC_T0] = events_i.timer0_overflow_flag;
		src_flags[irq_ctrl_pkg::SRC_IO1] = io_req[1];
		src_flags[irq_ctrl_pkg::SRC_T1] = events_i.timer1_overflow_flag;
		src_flags[irq_ctrl_pkg::SRC_T2] = events_i.timer2_overflow_flag | events_i.timer2_external_flag;
		src_flags[irq_ctrl_pkg::SRC_UART1] = events_i.uart1_tx_done_flag | events_i.uart1_rx_done_flag;
		src_flags[irq_ctrl_pkg::SRC_EXT8 +: irq_ctrl_pkg::EXT_FLAG_W] = ext_flags;
		src_flags[irq_ctrl_pkg::SRC_PD] = power_down_flag;
		src_enables = '0;
		src_enables[irq_ctrl_pkg::SRC_UART1:irq_ctrl_pkg::SRC_IO0] = interrupt_enable_main[irq_ctrl_pkg::MAIN_W-1:0];
		src_enables[irq_ctrl_pkg::SRC_EXT8 +: irq_ctrl_pkg::EXT_W] = extended_irq_enables;
		// the reserved serial enable steers nothing
		src_enables[irq_ctrl_pkg::SRC_T2 - 1] = 1'b0;
		src_prio = '0;
		src_prio[irq_ctrl_pkg::SRC_UART1:irq_ctrl_pkg::SRC_IO0] = priority_select_main;
		src_prio[irq_ctrl_pkg::SRC_EXT8 +: irq_ctrl_pkg::EXT_W] = extended_priority_select;
		active = src_flags & src_enables & {N{global_irq_gate}};
	end

	// ***********************************
	// priority resolution
	// ***********************************
	logic hi_found;
	logic lo_found;
	logic [NW-1:0] hi_idx;
	logic [NW-1:0] lo_idx;

	first_set_picker #(.N(N), .W(NW)) u_pick_hi (
		.req_i(active & src_prio),
		.found_o(hi_found),
		.idx_o(hi_idx)
	);

	first_set_picker #(.N(N), .W(NW)) u_pick_lo (
		.req_i(active & ~src_prio),
		.found_o(lo_found),
		.idx_o(lo_idx)
	);

	// level one may enter over a level-zero handler, level zero never preempts
	wire logic grant_hi = hi_found && !hi_busy;
	wire logic grant_lo = lo_found && !hi_busy && !lo_busy;
	wire logic next_req = (grant_hi || grant_lo) && !core_i.ack;
	wire logic [NW-1:0] next_num = grant_hi ? hi_idx : lo_idx;
	wire logic ack_edge0 = core_i.ack && irq_num_o == NW'(irq_ctrl_pkg::SRC_IO0);
	wire logic ack_edge1 = core_i.ack && irq_num_o == NW'(irq_ctrl_pkg::SRC_IO1);

	// ***********************************
	// read mux
	// ***********************************
	logic [7:0] read_val;

	always_comb
	begin
		if (sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_FLAGS)
			read_val = {ext_flags, 4'h0} | irq_ctrl_pkg::FLAGS_RSVD_ONES;
		else if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_MAIN)
			read_val = interrupt_enable_main;
		else if (sfr_addr_i == irq_ctrl_pkg::ADDR_PRIO_MAIN)
			read_val = {1'b0, priority_select_main} | irq_ctrl_pkg::PRIO_RSVD_ONES;
		else if (sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_CTRL)
			read_val = {uart1_baud_doubler_o, 3'h0, power_down_flag, 3'h0} | irq_ctrl_pkg::CTRL_RSVD_ONES;
		else if (sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_ENABLES)
			read_val = {3'h0, extended_irq_enables} | irq_ctrl_pkg::EXT_RSVD_ONES;
		else if (sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_PRIO)
			read_val = {3'h0, extended_priority_select} | irq_ctrl_pkg::EXT_RSVD_ONES;
		else
			read_val = irq_ctrl_pkg::READ_IDLE;
	end

	// ***********************************
	// configuration registers
	// ***********************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			interrupt_enable_main <= 8'h00;
			priority_select_main <= '0;
			extended_irq_enables <= '0;
			extended_priority_select <= '0;
			uart1_baud_doubler_o <= 1'b0;
			sfr_rdata_o <= 8'h00;
		end
		else
		begin
			if (wr_en_main)
				interrupt_enable_main <= sfr_wdata_i;
			if (wr_prio_main)
				priority_select_main <= sfr_wdata_i[irq_ctrl_pkg::MAIN_W-1:0];
			if (wr_ext_en)
				extended_irq_enables <= sfr_wdata_i[irq_ctrl_pkg::EXT_W-1:0];
			if (wr_ext_prio)
				extended_priority_select <= sfr_wdata_i[irq_ctrl_pkg::EXT_W-1:0];
			if (wr_ctrl)
				uart1_baud_doubler_o <= sfr_wdata_i[irq_ctrl_pkg::BAUD_BIT];
			if (sfr_rd_i)
				sfr_rdata_o <= read_val;
		end
	end

	// ***********************************
	// event flags, set wins over clear
	// ***********************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ext_flags <= '0;
			power_down_flag <= 1'b0;
			io_edge_flag <= 2'b00;
			io_prev <= 2'b00;
		end
		else
		begin
			// only a write clears the ext and power-down flags, an ack clears the io edge flags
			ext_flags <= (wr_flags ? sfr_wdata_i[irq_ctrl_pkg::EXT_FLAG_LSB +: irq_ctrl_pkg::EXT_FLAG_W] : ext_flags)
				| events_i.ext_event;
			power_down_flag <= (wr_ctrl ? sfr_wdata_i[irq_ctrl_pkg::PDF_BIT] : power_down_flag)
				| events_i.power_down_event;
			io_edge_flag <= (io_edge_flag & ~{ack_edge1, ack_edge0}) | io_fall;
			io_prev <= ~io_pin_low;
		end
	end

	// ***********************************
	// service tracking and request output
	// ***********************************
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hi_busy <= 1'b0;
			lo_busy <= 1'b0;
			irq_req_o <= 1'b0;
			irq_num_o <= '0;
			irq_level_o <= 1'b0;
			active_q <= '0;
			prio_q <= '0;
		end
		else
		begin
			if (core_i.ack && irq_level_o)
				hi_busy <= 1'b1;
			else if (core_i.reti && hi_busy)
				hi_busy <= 1'b0;
			if (core_i.ack && !irq_level_o)
				lo_busy <= 1'b1;
			else if (core_i.reti && !hi_busy)
				lo_busy <= 1'b0;
			irq_req_o <= next_req;
			irq_num_o <= next_num;
			irq_level_o <= grant_hi;
			active_q <= active;
			prio_q <= src_prio;
		end
	end

	// ***********************************
	// checks
	// ***********************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	wire logic [N-1:0] lower_mask = N'((N'(1) << irq_num_o) - N'(1));
	wire logic [N-1:0] same_level = irq_level_o ? prio_q : ~prio_q;
	wire logic wdata_baud = sfr_wdata_i[irq_ctrl_pkg::BAUD_BIT];

	property p_src_blocked(logic en, int num);
		!en |=> !(irq_req_o && irq_num_o == NW'(num));
	endproperty

	sequence s_pd_pending;
		active[irq_ctrl_pkg::SRC_PD] && !hi_busy && !lo_busy && !core_i.ack;
	endsequence

	sequence s_ext_sw_set;
		wr_flags && sfr_wdata_i[irq_ctrl_pkg::EXT_FLAG_LSB] && extended_irq_enables[0] && global_irq_gate;
	endsequence

	chk_gate_blocks_all: assert property (!global_irq_gate |=> !irq_req_o)
		else $error("request passed with global gate off");
	chk_uart1_gate: assert property (p_src_blocked(interrupt_enable_main[6], irq_ctrl_pkg::SRC_UART1))
		else $error("uart1 request while disabled");
	chk_timer2_gate: assert property (p_src_blocked(interrupt_enable_main[5], irq_ctrl_pkg::SRC_T2))
		else $error("timer2 request while disabled");
	chk_timer1_gate: assert property (p_src_blocked(interrupt_enable_main[3], irq_ctrl_pkg::SRC_T1))
		else $error("timer1 request while disabled");
	chk_timer0_gate: assert property (p_src_blocked(interrupt_enable_main[1], irq_ctrl_pkg::SRC_T0))
		else $error("timer0 request while disabled");
	chk_io_edge_catch: assert property (io_fall[0] |=> io_edge_flag[0])
		else $error("falling edge on io0 lost");
	chk_ext_en_read: assert property (sfr_rd_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_ENABLES
		|=> sfr_rdata_o == (irq_ctrl_pkg::EXT_RSVD_ONES | {3'h0, $past(extended_irq_enables)}))
		else $error("extended enable read mismatch");
	chk_ext_flag_set: assert property (|events_i.ext_event
		|=> (ext_flags & $past(events_i.ext_event)) == $past(events_i.ext_event))
		else $error("extended event did not set its flag");
	chk_ext_flag_hold: assert property (!wr_flags && ext_flags[0] |=> ext_flags[0])
		else $error("extended flag cleared without a write");
	chk_ext_sw_raise: assert property (s_ext_sw_set ##1 (!hi_busy && !lo_busy && !core_i.ack
		&& active[irq_ctrl_pkg::SRC_EXT8]) |=> irq_req_o)
		else $error("software set flag raised no request");
	chk_pd_repeats: assert property (s_pd_pending |=> irq_req_o)
		else $error("pending power-down not requested");
	chk_pd_sw_set: assert property (wr_ctrl && sfr_wdata_i[irq_ctrl_pkg::PDF_BIT] |=> power_down_flag)
		else $error("power-down flag not set by write");
	chk_baud_follow: assert property (wr_ctrl |=> uart1_baud_doubler_o == $past(wdata_baud))
		else $error("baud doubler not written");
	chk_flags_fixed: assert property (sfr_rd_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_FLAGS
		|=> sfr_rdata_o[3:0] == irq_ctrl_pkg::FLAGS_RSVD_ONES[3:0])
		else $error("reserved flag bits read wrong");
	chk_level_match: assert property (irq_req_o |-> irq_level_o == prio_q[irq_num_o])
		else $error("level does not match priority bit");
	chk_no_preempt_hi: assert property (hi_busy ##1 hi_busy |-> !irq_req_o)
		else $error("request during level one service");
	chk_lo_only_hi: assert property (lo_busy && irq_req_o |-> irq_level_o)
		else $error("level zero preempted a handler");
	chk_poll_order: assert property (irq_req_o |-> (active_q & same_level & lower_mask) == '0)
		else $error("polling order violated");
	chk_req_cause: assert property (irq_req_o |-> active_q[irq_num_o])
		else $error("request without flag, enable and gate");
	chk_io1_edge_catch: assert property (io_fall[1] |=> io_edge_flag[1])
		else $error("falling edge on io1 lost");
	chk_io1_edge_clear: assert property (ack_edge1 && !io_fall[1] |=> !io_edge_flag[1])
		else $error("io1 edge flag survived its ack");
	chk_ack_drops_req: assert property (core_i.ack |=> !irq_req_o)
		else $error("request presented again right after ack");
	chk_pd_flag_hold: assert property (!wr_ctrl && power_down_flag |=> power_down_flag)
		else $error("power-down flag cleared without a write");
	chk_baud_hold: assert property (!wr_ctrl |=> $stable(uart1_baud_doubler_o))
		else $error("baud doubler changed without a write");
	chk_gate_write: assert property (wr_en_main |=> interrupt_enable_main == $past(sfr_wdata_i))
		else $error("enable register not written");
	chk_flags_read: assert property (sfr_rd_i && sfr_addr_i == irq_ctrl_pkg::ADDR_EXT_FLAGS
		|=> sfr_rdata_o[irq_ctrl_pkg::EXT_FLAG_LSB +: irq_ctrl_pkg::EXT_FLAG_W] == $past(ext_flags))
		else $error("extended flags read mismatch");
endmodule
`default_nettype wire

/* tb/core_model.sv */
`default_nettype none
// ***********
// core side
// ***********
module core_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic irq_req_i,
	input wire logic ack_en_i,
	input wire logic [3:0] ack_wait_i,
	input wire logic reti_go_i,
	output var irq_ctrl_pkg::core_ctrl_t core_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] seen;
	// takes a request only after it stood ack_wait_i cycles, never twice in a row
	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			core_o <= '0;
			seen <= 4'h0;
		end
		else
		begin
			seen <= irq_req_i ? seen + 4'h1 : 4'h0;
			core_o.ack <= ack_en_i && irq_req_i && !core_o.ack && seen >= ack_wait_i;
			core_o.reti <= reti_go_i;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_cpu_irq_ctrl.sv */
`default_nettype none
module tb_cpu_irq_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	irq_ctrl_pkg::periph_events_t ev = '0;
	logic pin0 = 1'b1;
	logic pin1 = 1'b1;
	logic [1:0] mode = 2'b00;
	irq_ctrl_pkg::core_ctrl_t core;
	logic req;
	logic [3:0] num;
	logic lvl;
	logic baud;
	logic ack_en = 1'b0;
	logic reti_go = 1'b0;
	int n_errors = 0;
	int check_count = 0;
	always #10 clk_i = ~clk_i;
	cpu_irq_ctrl DUT (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
		.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .events_i(ev), .io_irq0_pin_i(pin0), .io_irq1_pin_i(pin1),
		.io_edge_mode_i(mode), .core_i(core), .irq_req_o(req), .irq_num_o(num), .irq_level_o(lvl),
		.uart1_baud_doubler_o(baud));
	core_model core_m (.clk_i(clk_i), .rstn_i(rstn_i), .irq_req_i(req), .ack_en_i(ack_en), .ack_wait_i(4'h3),
		.reti_go_i(reti_go), .core_o(core));
	// ***********
	// bus helpers
	// ***********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_i);
		addr = a;
		rd = 1'b1;
		@(negedge clk_i);
		rd = 1'b0;
		chk(rdata, e);
	endtask
	task automatic chk_req(input logic r, input logic [3:0] n, input logic l);
		repeat (2) @(negedge clk_i);
		if (r)
			chk({req, num, lvl}, {r, n, l});
		else
			chk(req, 1'b0);
	endtask
	task automatic take;
		ack_en = 1'b1;
		for (int i = 0; i < 20 && core.ack !== 1'b1; i++)
			@(negedge clk_i);
		ack_en = 1'b0;
		chk(core.ack, 1'b1);
	endtask
	task automatic reti_pulse;
		@(negedge clk_i);
		reti_go = 1'b1;
		@(negedge clk_i);
		reti_go = 1'b0;
	endtask
	// ***********
	// scenarios
	// ***********
	task automatic t_regs;
		logic [7:0] a[6] = '{8'h91, 8'ha8, 8'hb8, 8'hd8, 8'he8, 8'hf8};
		logic [7:0] r0[6] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'he0, 8'he0};
		logic [7:0] r1[6] = '{8'hf8, 8'hff, 8'hff, 8'hc8, 8'hff, 8'hff};
		for (int i = 0; i < 6; i++)
			rd_reg(a[i], r0[i]);
		rd_reg(8'h90, 8'h00);
		for (int i = 0; i < 6; i++)
			wr_reg(a[i], 8'hff);
		for (int i = 0; i < 6; i++)
			rd_reg(a[i], r1[i]);
		chk(baud, 1'b1);
		for (int i = 0; i < 6; i++)
			wr_reg(a[i], 8'h00);
		chk_req(1'b0, 4'h0, 1'b0);
		chk(baud, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_gate;
		int b[6] = '{1, 3, 5, 5, 6, 6};
		for (int k = 0; k < 6; k++)
		begin
			ev = 11'h400 >> k;
			wr_reg(8'ha8, 8'h01 << b[k]);
			chk_req(1'b0, 4'h0, 1'b0);
			wr_reg(8'ha8, 8'h80 | (8'h01 << b[k]));
			chk_req(1'b1, 4'(b[k]), 1'b0);
			wr_reg(8'ha8, 8'h80);
			chk_req(1'b0, 4'h0, 1'b0);
		end
		ev = '0;
		$display("test gate done");
	endtask
	task automatic t_ext;
		logic [7:0] fa;
		logic [7:0] fv;
		for (int k = 0; k < 5; k++)
		begin
			fa = k < 4 ? 8'h91 : 8'hd8;
			fv = k < 4 ? 8'h10 << k : 8'h08;
			wr_reg(8'he8, 8'h01 << k);
			wr_reg(8'ha8, 8'h80);
			wr_reg(fa, fv);
			chk_req(1'b1, 4'(8 + k), 1'b0);
			wr_reg(8'he8, 8'h00);
			chk_req(1'b0, 4'h0, 1'b0);
			rd_reg(fa, fv | (k < 4 ? 8'h08 : 8'h40));
			wr_reg(fa, 8'h00);
		end
		wr_reg(8'he8, 8'h10);
		wr_reg(8'hd8, 8'h08);
		chk_req(1'b1, 4'hc, 1'b0);
		take();
		chk_req(1'b0, 4'h0, 1'b0);
		reti_pulse();
		chk_req(1'b1, 4'hc, 1'b0);
		take();
		wr_reg(8'hd8, 8'h00);
		reti_pulse();
		chk_req(1'b0, 4'h0, 1'b0);
		wr_reg(8'he8, 8'h00);
		ev.ext_event = 4'h1;
		@(negedge clk_i);
		ev = '0;
		rd_reg(8'h91, 8'h18);
		wr_reg(8'h91, 8'h00);
		wr_reg(8'ha8, 8'h00);
		$display("test ext done");
	endtask
	task automatic t_prio;
		ev = 11'h600;
		wr_reg(8'ha8, 8'h8a);
		chk_req(1'b1, 4'h1, 1'b0);
		wr_reg(8'hb8, 8'h08);
		chk_req(1'b1, 4'h3, 1'b1);
		take();
		chk_req(1'b0, 4'h0, 1'b0);
		reti_pulse();
		chk_req(1'b1, 4'h3, 1'b1);
		ev.timer1_overflow_flag = 1'b0;
		chk_req(1'b1, 4'h1, 1'b0);
		take();
		ev.timer1_overflow_flag = 1'b1;
		chk_req(1'b1, 4'h3, 1'b1);
		take();
		reti_pulse();
		reti_pulse();
		ev = '0;
		wr_reg(8'hb8, 8'h00);
		wr_reg(8'he8, 8'h01);
		wr_reg(8'hf8, 8'h01);
		ev.timer0_overflow_flag = 1'b1;
		wr_reg(8'h91, 8'h10);
		chk_req(1'b1, 4'h8, 1'b1);
		wr_reg(8'h91, 8'h00);
		ev = '0;
		wr_reg(8'hf8, 8'h00);
		wr_reg(8'he8, 8'h00);
		$display("test prio done");
	endtask
	task automatic t_io;
		pin0 = 1'b0;
		wr_reg(8'ha8, 8'h81);
		repeat (4) @(negedge clk_i);
		chk_req(1'b1, 4'h0, 1'b0);
		wr_reg(8'ha8, 8'h80);
		chk_req(1'b0, 4'h0, 1'b0);
		pin0 = 1'b1;
		mode = 2'b10;
		wr_reg(8'ha8, 8'h84);
		pin1 = 1'b0;
		repeat (4) @(negedge clk_i);
		chk_req(1'b1, 4'h2, 1'b0);
		take();
		reti_pulse();
		chk_req(1'b0, 4'h0, 1'b0);
		mode = 2'b00;
		chk_req(1'b1, 4'h2, 1'b0);
		pin1 = 1'b1;
		mode = 2'b01;
		pin0 = 1'b0;
		wr_reg(8'ha8, 8'h81);
		repeat (4) @(negedge clk_i);
		chk_req(1'b1, 4'h0, 1'b0);
		take();
		reti_pulse();
		chk_req(1'b0, 4'h0, 1'b0);
		pin0 = 1'b1;
		wr_reg(8'ha8, 8'h00);
		$display("test io done");
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge clk_i);
		rstn_i = 1'b1;
		t_regs();
		t_gate();
		t_ext();
		t_prio();
		t_io();
		finish_test();
	end
	initial
	begin
		#400000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
